// [pkg/csar_pkg.sv]
package csar_pkg;

    // Register indices
    localparam logic [7:0] SYS_STATUS_IDX   = 8'h0B;
    localparam logic [7:0] FAULT_STATUS_IDX = 8'h0C;
    localparam logic [7:0] VIN_FLOOR_IDX    = 8'h0D;
    localparam logic [7:0] BATT_V_IDX       = 8'h0E;
    localparam logic [7:0] SYS_V_IDX        = 8'h0F;
    localparam logic [7:0] THERM_PCT_IDX    = 8'h10;
    localparam logic [7:0] VIN_V_IDX        = 8'h11;
    localparam logic [7:0] CHG_I_IDX        = 8'h12;
    localparam logic [7:0] LIMIT_STATUS_IDX = 8'h13;
    localparam logic [7:0] SOFT_RESET_IDX   = 8'h14;

    // Field positions
    localparam int SELECT_BIT    = 7;
    localparam int SOFT_RST_BIT  = 7;
    localparam int WD_FAULT_BIT  = 7;
    localparam int VIN_LIM_BIT   = 7;
    localparam int IIN_LIM_BIT   = 6;

    // Values after reset, and the data read from an unmapped index
    localparam logic       WD_FAULT_RST   = 1'b1;
    localparam logic       SELECT_RST     = 1'b0;
    localparam logic [6:0] FLOOR_RST      = 7'h12;
    localparam logic [6:0] READING_RST    = 7'h00;
    localparam logic [5:0] CAP_RST        = 6'h00;
    localparam logic [7:0] UNMAPPED_DATA  = 8'h00;

    // Floor codes: 2.6V + 100mV per count
    localparam logic [6:0] FLOOR_MIN_CODE = 7'h0D;
    localparam logic [6:0] REL_DOUBLE_CODE = 7'h22;

    // Source type encodings
    localparam logic [2:0] SRC_NONE    = 3'h0;
    localparam logic [2:0] SRC_USB_SDP = 3'h1;
    localparam logic [2:0] SRC_ADAPTER = 3'h2;
    localparam logic [2:0] SRC_OTG     = 3'h7;

    // Charge phase encodings
    localparam logic [1:0] PHASE_IDLE = 2'h0;
    localparam logic [1:0] PHASE_PRE  = 2'h1;
    localparam logic [1:0] PHASE_FAST = 2'h2;
    localparam logic [1:0] PHASE_DONE = 2'h3;

    // Charge fault encodings
    localparam logic [1:0] CFLT_NORMAL  = 2'h0;
    localparam logic [1:0] CFLT_INPUT   = 2'h1;
    localparam logic [1:0] CFLT_THERMAL = 2'h2;
    localparam logic [1:0] CFLT_TIMER   = 2'h3;

endpackage

// [design/csar_floor_calc.sv]
`timescale 1ns/1ps
`default_nettype none

module csar_floor_calc (
    input  wire logic       absolute_floor_select,
    input  wire logic [6:0] abs_floor_field,
    input  wire logic [6:0] noload_vin_code,
    input  wire logic [4:0] input_floor_offset,
    output logic      [6:0] relative_code,
    output logic      [6:0] effective_code
);

    logic [5:0] applied_offset;
    logic [7:0] lower_bound;

    always_comb begin
        // Offset doubles once the unloaded input sits above 6V
        if (noload_vin_code > csar_pkg::REL_DOUBLE_CODE) begin
            applied_offset = {input_floor_offset, 1'b0};
        end else begin
            applied_offset = {1'b0, input_floor_offset};
        end
        lower_bound = {2'b00, applied_offset} + {1'b0, csar_pkg::FLOOR_MIN_CODE};
        if ({1'b0, noload_vin_code} < lower_bound) begin
            relative_code = csar_pkg::FLOOR_MIN_CODE;
        end else begin
            relative_code = 7'(noload_vin_code - 7'(applied_offset));
        end
        if (!absolute_floor_select) begin
            effective_code = relative_code;
        end else if (abs_floor_field < csar_pkg::FLOOR_MIN_CODE) begin
            effective_code = csar_pkg::FLOOR_MIN_CODE;
        end else begin
            effective_code = abs_floor_field;
        end
    end

endmodule

`default_nettype wire

// [design/csar_regs.sv]
`timescale 1ns/1ps
`default_nettype none

module csar_regs (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_wr_data,
    input  wire logic       reg_rd_en,
    output logic      [7:0] reg_rd_data,
    input  wire logic [2:0] source_type,
    input  wire logic [1:0] charge_phase_code,
    input  wire logic       power_ok_flag,
    input  wire logic       sys_floor_reg_flag,
    input  wire logic       wd_expired,
    input  wire logic       wd_serviced,
    input  wire logic [1:0] charge_fault_code,
    input  wire logic       batt_overvoltage_flag,
    input  wire logic [2:0] ntc_fault_code,
    input  wire logic       thermal_limit_flag,
    input  wire logic       input_attached_flag,
    input  wire logic       batt_below_short,
    input  wire logic       adc_valid,
    input  wire logic [6:0] adc_batt_code,
    input  wire logic [6:0] adc_sys_code,
    input  wire logic [6:0] adc_therm_code,
    input  wire logic [6:0] adc_vin_code,
    input  wire logic [6:0] adc_chg_code,
    input  wire logic       vin_limit_active,
    input  wire logic       iin_limit_active,
    input  wire logic       input_power_search,
    input  wire logic [5:0] cap_in_force,
    input  wire logic [6:0] noload_vin_code,
    input  wire logic [4:0] input_floor_offset,
    output logic            absolute_floor_select,
    output logic      [6:0] vin_floor_code,
    output logic            settings_reset_pulse,
    output logic            safety_timer_restart
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] sys_status;
    logic [7:0] fault_live;
    logic       wd_fault;
    logic [6:0] floor_field;
    logic [6:0] batt_reading;
    logic [6:0] sys_reading;
    logic [6:0] therm_reading;
    logic [6:0] vin_reading;
    logic [6:0] chg_reading;
    logic [1:0] limit_flags;
    logic [5:0] cap_reading;
    logic       soft_rst_bit;

    logic [7:0] next_sys_status;
    logic [7:0] next_fault_live;
    logic       next_wd_fault;
    logic       next_select;
    logic [6:0] next_floor_field;
    logic [6:0] next_batt_reading;
    logic [6:0] next_sys_reading;
    logic [6:0] next_therm_reading;
    logic [6:0] next_vin_reading;
    logic [6:0] next_chg_reading;
    logic [1:0] next_limit_flags;
    logic [5:0] next_cap_reading;
    logic       next_soft_rst_bit;
    logic [7:0] next_rd_data;
    logic [6:0] next_vin_floor_code;
    logic       next_settings_reset;
    logic       next_timer_restart;

    logic [6:0] relative_code;
    logic [6:0] effective_code;
    logic       wr_floor;
    logic       wr_reset;

    assign wr_floor = reg_wr_en && (reg_addr == csar_pkg::VIN_FLOOR_IDX);
    assign wr_reset = reg_wr_en && (reg_addr == csar_pkg::SOFT_RESET_IDX);

    csar_floor_calc u_floor (
        .absolute_floor_select (absolute_floor_select),
        .abs_floor_field       (floor_field),
        .noload_vin_code       (noload_vin_code),
        .input_floor_offset    (input_floor_offset),
        .relative_code         (relative_code),
        .effective_code        (effective_code)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next values

    always_comb begin
        // Live status snapshots
        next_sys_status = {source_type, charge_phase_code,
                           power_ok_flag, 1'b0, sys_floor_reg_flag};
        next_fault_live = {1'b0, 1'b0, charge_fault_code,
                           batt_overvoltage_flag, ntc_fault_code};
        next_limit_flags = {vin_limit_active, iin_limit_active};

        // Watchdog fault: expiry beats a service in the same cycle
        if (wd_expired) begin
            next_wd_fault = 1'b1;
        end else if (wd_serviced) begin
            next_wd_fault = 1'b0;
        end else begin
            next_wd_fault = wd_fault;
        end

        // Conversion results
        next_batt_reading  = batt_reading;
        next_sys_reading   = sys_reading;
        next_therm_reading = therm_reading;
        next_vin_reading   = vin_reading;
        next_chg_reading   = chg_reading;
        if (adc_valid) begin
            next_batt_reading  = adc_batt_code;
            next_sys_reading   = adc_sys_code;
            next_therm_reading = adc_therm_code;
            next_vin_reading   = adc_vin_code;
            next_chg_reading   = adc_chg_code;
        end
        if (batt_below_short) begin
            next_chg_reading = 7'h00;
        end
        next_cap_reading = input_power_search ? cap_in_force : cap_reading;

        // Floor register
        next_select      = absolute_floor_select;
        next_floor_field = floor_field;
        if (wr_floor) begin
            next_select = reg_wr_data[csar_pkg::SELECT_BIT];
        end
        if (wr_floor && reg_wr_data[csar_pkg::SELECT_BIT]) begin
            next_floor_field = reg_wr_data[6:0];
        end else if (!next_select) begin
            next_floor_field = relative_code;
        end
        next_vin_floor_code = effective_code;

        // Soft reset request and self-clear
        next_soft_rst_bit   = 1'b0;
        next_settings_reset = 1'b0;
        next_timer_restart  = 1'b0;
        if (soft_rst_bit) begin
            next_settings_reset = 1'b1;
            next_timer_restart  = 1'b1;
            next_wd_fault       = csar_pkg::WD_FAULT_RST;
            next_select         = csar_pkg::SELECT_RST;
            next_floor_field    = csar_pkg::FLOOR_RST;
            next_batt_reading   = csar_pkg::READING_RST;
            next_sys_reading    = csar_pkg::READING_RST;
            next_therm_reading  = csar_pkg::READING_RST;
            next_vin_reading    = csar_pkg::READING_RST;
            next_chg_reading    = csar_pkg::READING_RST;
            next_cap_reading    = csar_pkg::CAP_RST;
        end else if (wr_reset) begin
            next_soft_rst_bit = reg_wr_data[csar_pkg::SOFT_RST_BIT];
        end

        // Read mux, free of side effects
        next_rd_data = reg_rd_data;
        if (reg_rd_en) begin
            if (reg_addr == csar_pkg::SYS_STATUS_IDX) begin
                next_rd_data = sys_status;
            end else if (reg_addr == csar_pkg::FAULT_STATUS_IDX) begin
                next_rd_data = {wd_fault, fault_live[6:0]};
            end else if (reg_addr == csar_pkg::VIN_FLOOR_IDX) begin
                next_rd_data = {absolute_floor_select, floor_field};
            end else if (reg_addr == csar_pkg::BATT_V_IDX) begin
                next_rd_data = {thermal_limit_flag, batt_reading};
            end else if (reg_addr == csar_pkg::SYS_V_IDX) begin
                next_rd_data = {1'b0, sys_reading};
            end else if (reg_addr == csar_pkg::THERM_PCT_IDX) begin
                next_rd_data = {1'b0, therm_reading};
            end else if (reg_addr == csar_pkg::VIN_V_IDX) begin
                next_rd_data = {input_attached_flag, vin_reading};
            end else if (reg_addr == csar_pkg::CHG_I_IDX) begin
                next_rd_data = {1'b0, chg_reading};
            end else if (reg_addr == csar_pkg::LIMIT_STATUS_IDX) begin
                next_rd_data = {limit_flags, cap_reading};
            end else if (reg_addr == csar_pkg::SOFT_RESET_IDX) begin
                next_rd_data = {soft_rst_bit, 7'h00};
            end else begin
                next_rd_data = csar_pkg::UNMAPPED_DATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sys_status            <= 8'h00;
            fault_live            <= 8'h00;
            wd_fault              <= csar_pkg::WD_FAULT_RST;
            absolute_floor_select <= csar_pkg::SELECT_RST;
            floor_field           <= csar_pkg::FLOOR_RST;
            batt_reading          <= csar_pkg::READING_RST;
            sys_reading           <= csar_pkg::READING_RST;
            therm_reading         <= csar_pkg::READING_RST;
            vin_reading           <= csar_pkg::READING_RST;
            chg_reading           <= csar_pkg::READING_RST;
            limit_flags           <= 2'h0;
            cap_reading           <= csar_pkg::CAP_RST;
            soft_rst_bit          <= 1'b0;
            reg_rd_data           <= 8'h00;
            vin_floor_code        <= csar_pkg::FLOOR_RST;
            settings_reset_pulse  <= 1'b0;
            safety_timer_restart  <= 1'b0;
        end else begin
            sys_status            <= next_sys_status;
            fault_live            <= next_fault_live;
            wd_fault              <= next_wd_fault;
            absolute_floor_select <= next_select;
            floor_field           <= next_floor_field;
            batt_reading          <= next_batt_reading;
            sys_reading           <= next_sys_reading;
            therm_reading         <= next_therm_reading;
            vin_reading           <= next_vin_reading;
            chg_reading           <= next_chg_reading;
            limit_flags           <= next_limit_flags;
            cap_reading           <= next_cap_reading;
            soft_rst_bit          <= next_soft_rst_bit;
            reg_rd_data           <= next_rd_data;
            vin_floor_code        <= next_vin_floor_code;
            settings_reset_pulse  <= next_settings_reset;
            safety_timer_restart  <= next_timer_restart;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence reset_written_s;
        wr_reset && reg_wr_data[7] && !soft_rst_bit;
    endsequence

    sequence reset_applied_s;
        settings_reset_pulse && safety_timer_restart && wd_fault
            && !absolute_floor_select && (floor_field == csar_pkg::FLOOR_RST);
    endsequence

    soft_reset_seq_a: assert property (
        reset_written_s |=> soft_rst_bit ##1 reset_applied_s)
        else $error("soft reset did not restore defaults");

    reset_self_clear_a: assert property (
        soft_rst_bit |=> !soft_rst_bit)
        else $error("reset bit did not clear itself");

    reset_zero_write_a: assert property (
        wr_reset && !reg_wr_data[7] && !soft_rst_bit |=> !soft_rst_bit ##1 !settings_reset_pulse)
        else $error("writing zero started a reset");

    status_read_a: assert property (
        reg_rd_en && reg_addr == csar_pkg::SYS_STATUS_IDX && $past(arst_n)
            |=> reg_rd_data == {$past(source_type, 2), $past(charge_phase_code, 2),
                                $past(power_ok_flag, 2), 1'b0, $past(sys_floor_reg_flag, 2)})
        else $error("system status read wrong");

    wd_fault_set_a: assert property (
        wd_expired ##1 (reg_rd_en && reg_addr == csar_pkg::FAULT_STATUS_IDX)
            |=> reg_rd_data[7])
        else $error("watchdog fault flag lost");

    floor_locked_a: assert property (
        wr_floor && !reg_wr_data[7] && !soft_rst_bit |=> floor_field == $past(relative_code))
        else $error("floor field written while relative");

    floor_clamp_a: assert property (
        ##1 vin_floor_code >= csar_pkg::FLOOR_MIN_CODE)
        else $error("floor below 3.9V");

    chg_short_zero_a: assert property (
        batt_below_short |=> chg_reading == 7'h00)
        else $error("charge current not zeroed");

    sys_top_zero_a: assert property (
        reg_rd_en && reg_addr == csar_pkg::SYS_V_IDX |=> !reg_rd_data[7])
        else $error("system reading top bit set");

    cap_follow_a: assert property (
        input_power_search && !soft_rst_bit && arst_n |=> cap_reading == $past(cap_in_force))
        else $error("effective cap not latched");

endmodule

`default_nettype wire

// [dv/csar_host.sv]
`timescale 1ns/1ps
`default_nettype none

module csar_host (
    input  wire logic       sys_clk,
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr_en,
    output var  logic [7:0] reg_wr_data,
    output var  logic       reg_rd_en,
    input  wire logic [7:0] reg_rd_data
);
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end

    // Address is scrambled once released so a stale index never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wr_data <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rd_data;
    endtask
endmodule

`default_nettype wire

// [dv/charger_status_adc_registers_test.sv]
`timescale 1ns/1ps
`default_nettype none

module charger_status_adc_registers_test;
    typedef struct packed {
        logic [29:0] stim;
        logic [7:0][7:0] exp;
    } csar_row_t;

    // Stimulus: source, phase, fault, ntc, cap, code, flags; reads 0B 0C 0E..13
    localparam csar_row_t ROWS [4] = '{
        '{{3'h0, 2'h0, 2'h0, 3'h2, 6'h00, 7'h00, 7'h3A}, 64'h010A_8000_0000_0080},
        '{{3'h1, 2'h1, 2'h1, 3'h5, 6'h3F, 7'h7F, 7'h45}, 64'h2C15_7F7F_7FFF_7F7F},
        '{{3'h2, 2'h2, 2'h2, 3'h6, 6'h15, 7'h2A, 7'h3F}, 64'h512E_AA2A_2AAA_2AD5},
        '{{3'h7, 2'h3, 2'h3, 3'h3, 6'h2A, 7'h55, 7'h60}, 64'hFD33_5555_5555_552A}
    };
    // Unloaded input, offset, expected floor code
    localparam logic [18:0] FL [5] = '{
        {7'h18, 5'h06, 7'h12}, {7'h22, 5'h06, 7'h1C}, {7'h23, 5'h06, 7'h17},
        {7'h10, 5'h06, 7'h0D}, {7'h7F, 5'h1F, 7'h41}
    };

    logic        sys_clk, arst_n, power_ok_flag, sys_floor_reg_flag, wd_expired;
    logic        wd_serviced, batt_overvoltage_flag, thermal_limit_flag, input_attached_flag;
    logic        batt_below_short, adc_valid, vin_limit_active, iin_limit_active;
    logic        input_power_search, absolute_floor_select, settings_reset_pulse;
    logic        safety_timer_restart, reg_wr_en, reg_rd_en;
    logic [1:0]  charge_phase_code, charge_fault_code;
    logic [2:0]  source_type, ntc_fault_code;
    logic [4:0]  input_floor_offset;
    logic [5:0]  cap_in_force;
    logic [6:0]  adc_code, noload_vin_code, vin_floor_code;
    logic [7:0]  reg_addr, reg_wr_data, reg_rd_data, got;
    logic [29:0] row_in;
    int          n_errors, checks, n_pulse, n_restart;

    assign {source_type, charge_phase_code, charge_fault_code, ntc_fault_code, cap_in_force,
            adc_code, power_ok_flag, sys_floor_reg_flag, batt_overvoltage_flag,
            vin_limit_active, iin_limit_active, thermal_limit_flag,
            input_attached_flag} = row_in;

    csar_regs dut (
        .sys_clk, .arst_n, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
        .source_type, .charge_phase_code, .power_ok_flag, .sys_floor_reg_flag, .wd_expired,
        .wd_serviced, .charge_fault_code, .batt_overvoltage_flag, .ntc_fault_code,
        .thermal_limit_flag, .input_attached_flag, .batt_below_short, .adc_valid,
        .adc_batt_code(adc_code), .adc_sys_code(adc_code), .adc_therm_code(adc_code),
        .adc_vin_code(adc_code), .adc_chg_code(adc_code), .vin_limit_active,
        .iin_limit_active, .input_power_search, .cap_in_force, .noload_vin_code,
        .input_floor_offset, .absolute_floor_select, .vin_floor_code, .settings_reset_pulse,
        .safety_timer_restart
    );

    csar_host host (
        .sys_clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data
    );

    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        n_pulse += settings_reset_pulse;
        n_restart += safety_timer_restart;
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, got);
        chk(got, e);
    endtask

    task automatic service_wd;
        @(posedge sys_clk);
        wd_serviced <= 1'b1;
        @(posedge sys_clk);
        wd_serviced <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic stop_test;
        $display("Mismatches: %0d, comparisons: %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #100us;
        n_errors++;
        stop_test();
    end

    initial begin
        sys_clk = 1'b0;
        arst_n = 1'b0;
        row_in = '0;
        {wd_expired, wd_serviced, batt_below_short, adc_valid} = '0;
        input_power_search = 1'b1;
        noload_vin_code = 7'h18;
        input_floor_offset = 5'h06;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_chk(csar_pkg::FAULT_STATUS_IDX, 8'h80);
        service_wd();
        foreach (ROWS[i]) begin
            @(posedge sys_clk);
            row_in <= ROWS[i].stim;
            adc_valid <= 1'b1;
            @(posedge sys_clk);
            adc_valid <= 1'b0;
            repeat (2) @(posedge sys_clk);
            for (int j = 0; j < 2; j++) begin
                rd_chk(8'(11 + j), ROWS[i].exp[7 - j]);
            end
            for (int j = 2; j < 5; j++) begin
                rd_chk(8'(12 + j), ROWS[i].exp[7 - j]);
            end
            for (int j = 5; j < 8; j++) begin
                rd_chk(8'(12 + j), ROWS[i].exp[7 - j]);
            end
        end
        // Expiry and service in one cycle: the set wins; a second read sees the same byte
        @(posedge sys_clk);
        wd_expired <= 1'b1;
        wd_serviced <= 1'b1;
        rd_chk(csar_pkg::FAULT_STATUS_IDX, 8'hB3);
        @(posedge sys_clk);
        wd_expired <= 1'b0;
        wd_serviced <= 1'b0;
        rd_chk(csar_pkg::FAULT_STATUS_IDX, 8'hB3);
        // Short battery overrides a fresh conversion
        @(posedge sys_clk);
        batt_below_short <= 1'b1;
        adc_valid <= 1'b1;
        @(posedge sys_clk);
        adc_valid <= 1'b0;
        rd_chk(csar_pkg::CHG_I_IDX, 8'h00);
        // Relative floor: a field write with bit 7 clear is ignored
        host.wr(csar_pkg::VIN_FLOOR_IDX, 8'h05);
        foreach (FL[i]) begin
            @(posedge sys_clk);
            {noload_vin_code, input_floor_offset} <= FL[i][18:7];
            repeat (3) @(posedge sys_clk);
            #1 chk({1'b0, vin_floor_code}, {1'b0, FL[i][6:0]});
            rd_chk(csar_pkg::VIN_FLOOR_IDX, {1'b0, FL[i][6:0]});
        end
        // Absolute floor, clamped below the minimum code
        host.wr(csar_pkg::VIN_FLOOR_IDX, 8'h85);
        repeat (2) @(posedge sys_clk);
        #1 chk({7'h00, absolute_floor_select}, 8'h01);
        chk({1'b0, vin_floor_code}, 8'h0D);
        rd_chk(csar_pkg::VIN_FLOOR_IDX, 8'h85);
        host.wr(csar_pkg::VIN_FLOOR_IDX, 8'h7F);
        rd_chk(csar_pkg::VIN_FLOOR_IDX, 8'h41);
        host.wr(csar_pkg::VIN_FLOOR_IDX, 8'hC0);
        repeat (2) @(posedge sys_clk);
        #1 chk({1'b0, vin_floor_code}, 8'h40);
        // Soft reset: a zero write does nothing, a one restores defaults once
        service_wd();
        host.wr(csar_pkg::SOFT_RESET_IDX, 8'h00);
        host.wr(csar_pkg::SOFT_RESET_IDX, 8'h80);
        @(posedge sys_clk);
        #1 chk({6'h00, settings_reset_pulse, safety_timer_restart}, 8'h03);
        rd_chk(csar_pkg::SOFT_RESET_IDX, 8'h00);
        rd_chk(csar_pkg::VIN_FLOOR_IDX, 8'h41);
        rd_chk(csar_pkg::FAULT_STATUS_IDX, 8'hB3);
        rd_chk(csar_pkg::BATT_V_IDX, 8'h00);
        chk({n_pulse[3:0], n_restart[3:0]}, 8'h11);
        // Second hard reset in mid-run; with power search off the cap keeps its default
        @(posedge sys_clk);
        arst_n <= 1'b0;
        input_power_search <= 1'b0;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_chk(csar_pkg::BATT_V_IDX, 8'h00);
        rd_chk(csar_pkg::FAULT_STATUS_IDX, 8'hB3);
        rd_chk(csar_pkg::LIMIT_STATUS_IDX, 8'h00);
        rd_chk(8'h20, 8'h00);
        stop_test();
    end
endmodule

`default_nettype wire
